// [t1_transmit_formatter.sv]
// t1 transmit formatter: serialiser, framing, stuffing, polar outputs, apb control
// assumes all pins synchronous to i_clock; apb slave answers with zero wait states
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module t1_transmit_formatter (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [t1_fmt_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [7:0] i_sample_in,
   input wire logic i_alarm_in,
   input wire logic i_sig_a_in,
   input wire logic i_sig_b_in,
   input wire logic i_s_bit_in,
   input wire logic i_slot_align_in,
   input wire logic i_superframe_align_in,
   output logic o_serial_binary_out,
   output logic o_polar_out_pos,
   output logic o_polar_out_neg,
   output logic o_slot_clock_n,
   output logic o_frame_start_pulse,
   output logic o_superframe_strobe
);
   localparam int DW = $clog2(t1_fmt_pkg::DIV_CYCLES);
   localparam logic [DW-1:0] DIV_LAST = DW'(t1_fmt_pkg::DIV_CYCLES - 1);
   localparam logic [DW-1:0] DIV_HALF = DW'(t1_fmt_pkg::HALF_CYCLES - 1);

   // applies stuffing, signalling and alarm to one latched channel sample
   function automatic logic [7:0] format_sample(input t1_fmt_pkg::chan_in_t h,
         input t1_fmt_pkg::ctrl_t c, input logic [3:0] fr);
      logic [7:0] d;
      logic sig_frame;
      logic sig_bit;
      d = h.sample;
      sig_frame = !c.common_chan_mode &&
         (fr == t1_fmt_pkg::SIG_A_FRAME || fr == t1_fmt_pkg::SIG_B_FRAME);
      sig_bit = (fr == t1_fmt_pkg::SIG_A_FRAME) ? h.sig_a : h.sig_b;
      if (sig_frame) begin
         d[t1_fmt_pkg::B8_POS] = sig_bit;
      end
      if (!c.zero_monitor_disable) begin
         if (sig_frame) begin
            if (d == 8'h00) begin
               d[t1_fmt_pkg::B7_POS] = 1'b1;
            end
         end else if (d == 8'h00) begin
            if (c.stuff_pos_select) begin
               d[t1_fmt_pkg::B7_POS] = 1'b1;
            end else begin
               d[t1_fmt_pkg::B8_POS] = 1'b1;
            end
         end
      end
      if (h.alarm) begin
         d[t1_fmt_pkg::B2_POS] = 1'b0;
      end
      return d;
   endfunction

   logic [DW-1:0] div_q;
   logic [2:0] bit_q;
   logic [4:0] chan_q;
   logic [3:0] frame_q;
   logic next_fbit_q;
   logic frame_hold_q;
   logic out_fbit_q;
   t1_fmt_pkg::chan_in_t hold_q;
   t1_fmt_pkg::ctrl_t ctrl_q;
   logic [7:0] shift_q;
   logic bin_q;
   logic pol_q;
   logic pos_q;
   logic neg_q;
   logic alt_q;
   logic slot_clk_q;
   logic pulse_q;
   logic strobe_q;
   logic [31:0] prdata_q;

   wire bit_tick = (div_q == DIV_LAST);
   wire half_tick = (div_q == DIV_HALF);
   wire chan_end = (bit_q == t1_fmt_pkg::LAST_BIT);
   wire frame_end = ctrl_q.test_mode ?
      (chan_q == t1_fmt_pkg::TEST_LAST_CHAN && bit_q == t1_fmt_pkg::TEST_LAST_BIT) :
      (chan_q == t1_fmt_pkg::LAST_CHAN && chan_end);
   wire load_now = !next_fbit_q && (bit_q == 3'h0);
   wire capture = bit_tick && !next_fbit_q && (chan_end || frame_end);
   wire [3:0] frame_inc = (frame_q == t1_fmt_pkg::LAST_FRAME) ?
      t1_fmt_pkg::FIRST_FRAME : frame_q + 4'h1;
   wire [3:0] frame_new = frame_hold_q ? frame_q : frame_inc;
   wire [7:0] fmt = format_sample(hold_q, ctrl_q, frame_q);
   wire fbit_val = !frame_new[0] ? !frame_new[1] :
      (ctrl_q.common_chan_mode ? i_s_bit_in : t1_fmt_pkg::MF_PATTERN[frame_new]);
   wire bit_val = next_fbit_q ? fbit_val :
      (load_now ? fmt[t1_fmt_pkg::SIGN_POS] : shift_q[t1_fmt_pkg::SIGN_POS]);
   wire polar_one = ctrl_q.loop_test ? !alt_q : bit_val;
   wire slot_clk_d = !next_fbit_q && !chan_end && !frame_end &&
      (bit_q >= t1_fmt_pkg::SLOT_CLK_RISE);
   wire apb_setup = i_psel && !i_penable;
   wire apb_access = i_psel && i_penable;
   wire ctrl_hit = (i_paddr == t1_fmt_pkg::CTRL_ADDR);
   wire stat_hit = (i_paddr == t1_fmt_pkg::STAT_ADDR);
   // status word: frame [3:0], channel [12:8], bit [18:16], framing flag [24]
   wire [31:0] rd_mux = ctrl_hit ? {27'h0, ctrl_q} :
      (stat_hit ? {7'h00, next_fbit_q, 5'h00, bit_q, 3'h0, chan_q, 4'h0, frame_q} : 32'h0);

   // bit-rate divider, realigned by slot align
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         div_q <= '0;
      end else if (i_slot_align_in || bit_tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + DW'(1);
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bit_q <= 3'h0;
         chan_q <= 5'h00;
         next_fbit_q <= 1'b1;
      end else if (i_slot_align_in) begin
         bit_q <= 3'h0;
         chan_q <= 5'h00;
         next_fbit_q <= 1'b0;
      end else if (bit_tick) begin
         if (next_fbit_q) begin
            next_fbit_q <= 1'b0;
            bit_q <= 3'h0;
            chan_q <= 5'h00;
         end else if (frame_end) begin
            next_fbit_q <= 1'b1;
         end else if (chan_end) begin
            bit_q <= 3'h0;
            chan_q <= chan_q + 5'h01;
         end else begin
            bit_q <= bit_q + 3'h1;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         frame_q <= t1_fmt_pkg::FIRST_FRAME;
         frame_hold_q <= 1'b1;
         strobe_q <= 1'b1;
      end else if (i_superframe_align_in) begin
         frame_q <= t1_fmt_pkg::FIRST_FRAME;
         frame_hold_q <= 1'b1;
         strobe_q <= 1'b1;
      end else if (bit_tick && next_fbit_q) begin
         frame_q <= frame_new;
         frame_hold_q <= 1'b0;
         strobe_q <= !frame_new[0];
      end
   end

   // input register capture at slot clock fall and, in test mode, at the test frame end
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hold_q <= '0;
      end else if (capture) begin
         hold_q <= {i_sample_in, i_alarm_in, i_sig_a_in, i_sig_b_in};
      end
   end

   // parallel load then shift, sign bit first
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         shift_q <= 8'h00;
         bin_q <= 1'b0;
         out_fbit_q <= 1'b0;
         slot_clk_q <= 1'b1;
      end else if (bit_tick) begin
         shift_q <= load_now ? {fmt[6:0], 1'b0} : {shift_q[6:0], 1'b0};
         bin_q <= bit_val;
         out_fbit_q <= next_fbit_q;
         slot_clk_q <= slot_clk_d;
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pol_q <= 1'b0;
         pos_q <= 1'b0;
         neg_q <= 1'b0;
         alt_q <= 1'b0;
      end else if (bit_tick) begin
         alt_q <= !alt_q;
         if (polar_one) begin
            pol_q <= !pol_q;
            pos_q <= !pol_q;
            neg_q <= pol_q;
         end else begin
            pos_q <= 1'b0;
            neg_q <= 1'b0;
         end
      end
   end

   // frame pulse on the mid-bit edge of the framing bit
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pulse_q <= 1'b0;
      end else if (half_tick) begin
         pulse_q <= out_fbit_q;
      end
   end

   // apb control and read data
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_q <= t1_fmt_pkg::CTRL_RESET;
         prdata_q <= 32'h0;
      end else begin
         if (apb_setup) begin
            prdata_q <= rd_mux;
         end
         if (apb_access && i_pwrite && ctrl_hit) begin
            ctrl_q <= i_pwdata[4:0];
         end
      end
   end

   assign o_prdata = prdata_q;
   assign o_pready = 1'b1;
   assign o_pslverr = apb_access && !ctrl_hit && !stat_hit;
   assign o_serial_binary_out = bin_q;
   assign o_polar_out_pos = pos_q;
   assign o_polar_out_neg = neg_q;
   assign o_slot_clock_n = slot_clk_q;
   assign o_frame_start_pulse = pulse_q;
   assign o_superframe_strobe = strobe_q;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   sequence emit_last_s;
      bit_tick && !next_fbit_q && chan_end && !frame_end && !i_slot_align_in;
   endsequence
   sequence frame_over_s;
      bit_tick && next_fbit_q && !i_slot_align_in;
   endsequence
   sequence emit_zero_s;
      bit_tick && !ctrl_q.loop_test && !bit_val;
   endsequence
   sequence emit_one_s;
      bit_tick && !ctrl_q.loop_test && bit_val;
   endsequence

   polar_zero_a: assert property (emit_zero_s |=> !pos_q && !neg_q)
      else $error("polar outputs high during a zero");
   polar_compl_a: assert property (emit_one_s |=> pos_q != neg_q)
      else $error("polar outputs not complementary on a one");
   polar_toggle_a: assert property (bit_tick && polar_one |=> pol_q != $past(pol_q))
      else $error("polarity did not alternate on a one");
   bit_wrap_a: assert property (emit_last_s |=> bit_q == 3'h0 && chan_q == $past(chan_q) + 5'h01)
      else $error("channel did not advance after bit 8");
   frame_restart_a: assert property (frame_over_s |=> chan_q == 5'h00 && bit_q == 3'h0)
      else $error("framing bit not followed by channel 1");
   // slot align holds the divider and so stretches a pulse in flight
   pulse_width_a: assert property (disable iff (i_sys_rst || i_slot_align_in)
      $rose(pulse_q) |-> pulse_q [*8] ##19 $fell(pulse_q))
      else $error("frame pulse width wrong");
   slot_align_a: assert property (i_slot_align_in |=> !next_fbit_q && bit_q == 3'h0 && chan_q == 5'h00)
      else $error("slot align did not reset counters");
   frame_align_a: assert property (i_superframe_align_in |=> frame_q == t1_fmt_pkg::FIRST_FRAME && strobe_q)
      else $error("superframe align did not set frame 1");
   alarm_bit_a: assert property (bit_tick && load_now && hold_q.alarm && !i_slot_align_in |=> !shift_q[7])
      else $error("bit 2 not zero under alarm");
   capture_time_a: assert property (capture && !i_slot_align_in |=> !slot_clk_q && hold_q.sample == $past(i_sample_in))
      else $error("sample not captured at slot clock fall");
   latch_group_a: assert property (capture && !i_slot_align_in |=>
      hold_q.alarm == $past(i_alarm_in) && hold_q.sig_a == $past(i_sig_a_in) &&
      hold_q.sig_b == $past(i_sig_b_in))
      else $error("alarm or signalling not latched with the sample");
   slot_fbit_a: assert property (frame_over_s |=> !slot_clk_q && out_fbit_q)
      else $error("slot clock high during the framing bit");
   frame_wrap_a: assert property (frame_over_s && !frame_hold_q &&
      !i_superframe_align_in && frame_q == t1_fmt_pkg::LAST_FRAME |=>
      frame_q == t1_fmt_pkg::FIRST_FRAME)
      else $error("frame counter did not wrap after the last frame");
   fbit_odd_a: assert property (frame_over_s && !i_superframe_align_in |=>
      frame_q[0] || bin_q == (frame_q[1:0] == 2'h0))
      else $error("frame alignment bit wrong");
   mf_pattern_a: assert property (frame_over_s && !ctrl_q.common_chan_mode &&
      !i_superframe_align_in |=> !frame_q[0] || bin_q == t1_fmt_pkg::MF_PATTERN[frame_q])
      else $error("multiframe alignment bit wrong");
   sbit_path_a: assert property (frame_over_s && ctrl_q.common_chan_mode &&
      !i_superframe_align_in |=> !frame_q[0] || bin_q == $past(i_s_bit_in))
      else $error("external s bit not sent");
endmodule // t1_transmit_formatter
`default_nettype wire

// [t1_fmt_pkg.sv]
// constants, register map and carrier types of the t1 transmit formatter
// assumes a single 40 MHz system clock; the bit rate is made by a divider
package t1_fmt_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int BIT_HZ = 1544000;
   localparam int DIV_CYCLES = (CLK_HZ + BIT_HZ / 2) / BIT_HZ;
   localparam int HALF_CYCLES = DIV_CYCLES / 2;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] SLOT_CLK_RISE = 3'h3;
   localparam logic [4:0] LAST_CHAN = 5'h17;
   localparam logic [3:0] LAST_FRAME = 4'hb;
   localparam logic [3:0] FIRST_FRAME = 4'h0;
   localparam logic [3:0] SIG_A_FRAME = 4'h5;
   localparam logic [3:0] SIG_B_FRAME = 4'hb;
   // 13-bit test frame: framing bit, channel 1, first four bits of channel 2
   localparam logic [4:0] TEST_LAST_CHAN = 5'h01;
   localparam logic [2:0] TEST_LAST_BIT = 3'h3;
   // multiframe pattern indexed by frame index (0 = frame 1)
   localparam logic [11:0] MF_PATTERN = 12'h2a0;
   localparam int SIGN_POS = 7;
   localparam int B2_POS = 6;
   localparam int B7_POS = 1;
   localparam int B8_POS = 0;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
   localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h004;
   typedef struct packed {
      logic test_mode;
      logic loop_test;
      logic common_chan_mode;
      logic stuff_pos_select;
      logic zero_monitor_disable;
   } ctrl_t;
   localparam ctrl_t CTRL_RESET = 5'h00;
   typedef struct packed {
      logic [7:0] sample;
      logic alarm;
      logic sig_a;
      logic sig_b;
   } chan_in_t;
endpackage

// [chan_source_model.sv]
// channel sample source in front of the formatter's parallel inputs
// assumes capture happens at the bit tick on which slot clock falls
`timescale 1ns/1ps
`default_nettype none
module chan_source_model (
   input wire logic i_clock,
   input wire logic i_slot_clock_n,
   input wire t1_fmt_pkg::chan_in_t i_next,
   output var t1_fmt_pkg::chan_in_t o_chan
);
   logic slot_q;
   initial o_chan = '0;
   always @(posedge i_clock) begin
      slot_q <= i_slot_clock_n;
      if (slot_q && !i_slot_clock_n) begin
         o_chan <= i_next;
      end
   end
endmodule // chan_source_model
`default_nettype wire

// [t1_transmit_formatter_tb.sv]
// bench for the t1 transmit formatter, mostly in the 13-bit test frame
// assumes zero-wait apb and a bit period of DIV_CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module t1_transmit_formatter_tb;
   localparam int P = t1_fmt_pkg::DIV_CYCLES;
   logic i_clock, i_sys_rst, psel, penable, pwrite, s_bit, slot_al, sf_al, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, bin, pos, neg, slot_n, fpulse, superframe_strobe, st, seen, lastp;
   logic [12:0] bits, scl;
   t1_fmt_pkg::chan_in_t nxt, chan;
   int failures, checks_done;

   t1_transmit_formatter DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_sample_in(chan.sample), .i_alarm_in(chan.alarm), .i_sig_a_in(chan.sig_a),
      .i_sig_b_in(chan.sig_b), .i_s_bit_in(s_bit), .i_slot_align_in(slot_al),
      .i_superframe_align_in(sf_al), .o_serial_binary_out(bin), .o_polar_out_pos(pos),
      .o_polar_out_neg(neg), .o_slot_clock_n(slot_n), .o_frame_start_pulse(fpulse),
      .o_superframe_strobe(superframe_strobe));
   chan_source_model src (.i_clock(i_clock), .i_slot_clock_n(slot_n), .i_next(nxt),
      .o_chan(chan));

   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      do begin
         @(posedge i_clock);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [7:0] fmt(int f, t1_fmt_pkg::ctrl_t c, t1_fmt_pkg::chan_in_t x);
      logic [7:0] v;
      logic sg;
      sg = (f == 6 || f == 12) && !c.common_chan_mode;
      v = x.sample;
      if (sg) v[0] = (f == 6) ? x.sig_a : x.sig_b;
      if (!c.zero_monitor_disable && v == 8'h00) begin
         if (sg || c.stuff_pos_select) v[1] = 1'b1;
         else v[0] = 1'b1;
      end
      if (x.alarm) v[6] = 1'b0;
      return v;
   endfunction

   function automatic logic fbit(int f, t1_fmt_pkg::ctrl_t c, logic s);
      if (f % 2 == 1) return f % 4 == 1;
      if (c.common_chan_mode) return s;
      return f >= 6 && f <= 10;
   endfunction

   // one frame from the pulse on, sampled mid-bit, polar pair checked per bit
   task automatic grab(input logic lp);
      int k;
      @(posedge fpulse);
      for (k = 0; k < 13; k++) begin
         if (k > 0) repeat (P) @(posedge i_clock);
         #1;
         bits[12-k] = bin;
         scl[12-k] = slot_n;
         if (k == 0) st = superframe_strobe;
         if (k == 1) chk({31'h0, fpulse}, 32'h0, "pulse");
         if (lp && seen) chk({31'h0, pos | neg}, {31'h0, ~lastp}, "loop");
         else if (!lp && bin === 1'b0) chk({30'h0, pos, neg}, 32'h0, "zero");
         else if (!lp && seen) chk({30'h0, pos, neg}, {30'h0, ~lastp, lastp}, "one");
         if (lp || bin === 1'b1) begin
            seen = 1'b1;
            lastp = lp ? (pos | neg) : pos;
         end
      end
   endtask

   task automatic run(input logic [4:0] cb, input t1_fmt_pkg::chan_in_t x, input logic s);
      t1_fmt_pkg::ctrl_t c;
      logic [7:0] v;
      c = cb;
      apb(1'b1, t1_fmt_pkg::CTRL_ADDR, {27'h0, cb});
      nxt <= x;
      s_bit <= s;
      seen = 1'b0;
      grab(c.loop_test);
      grab(c.loop_test);
      @(posedge i_clock);
      sf_al <= 1'b1;
      @(posedge i_clock);
      sf_al <= 1'b0;
      for (int f = 1; f <= 12; f++) begin
         grab(c.loop_test);
         v = fmt(f, c, x);
         chk({31'h0, st}, 32'(f % 2), "strobe");
         chk({19'h0, bits}, {19'h0, fbit(f, c, s), v, v[7:4]}, "frame");
         chk({23'h0, scl[12:4]}, 32'h1e, "slot clk");
      end
   endtask

   initial begin
      #(90000 * 25);
      failures++;
      final_report();
   end

   initial begin
      time t0;
      logic [7:0] v;
      {i_sys_rst, psel, penable, pwrite, s_bit, slot_al, sf_al} = 7'h40;
      paddr = 12'h000;
      pwdata = 32'h0;
      nxt = {8'hc5, 3'b011};
      failures = 0;
      checks_done = 0;
      repeat (20) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      apb(1'b0, t1_fmt_pkg::STAT_ADDR, 32'h0);
      chk(rd, 32'h0100_0000, "stat reset");
      apb(1'b0, t1_fmt_pkg::CTRL_ADDR, 32'h0);
      chk(rd, 32'h0, "ctrl reset");
      apb(1'b1, 12'h008, 32'hffff_ffff);
      chk({31'h0, er}, 32'h1, "unmapped wr");
      apb(1'b0, 12'h008, 32'h0);
      chk(rd | {31'h0, ~er}, 32'h0, "unmapped rd");
      apb(1'b1, t1_fmt_pkg::CTRL_ADDR, 32'hffff_ffff);
      apb(1'b0, t1_fmt_pkg::CTRL_ADDR, 32'h0);
      chk(rd, 32'h1f, "ctrl rw");
      apb(1'b1, t1_fmt_pkg::CTRL_ADDR, 32'h0);
      @(posedge fpulse);
      t0 = $time;
      @(posedge fpulse);
      chk(32'(($time - t0) / 25), 32'(193 * P), "frame len");
      @(posedge i_clock);
      slot_al <= 1'b1;
      repeat (4) @(posedge i_clock);
      slot_al <= 1'b0;
      repeat (P + P / 2) @(posedge i_clock);
      for (int k = 0; k < 8; k++) begin
         #1;
         v[7-k] = bin;
         repeat (P) @(posedge i_clock);
      end
      chk({24'h0, v}, 32'hc5, "align");
      run(5'h10, {8'hc4, 3'b010}, 1'b0);
      run(5'h10, {8'h00, 3'b000}, 1'b0);
      run(5'h12, {8'h00, 3'b001}, 1'b0);
      run(5'h11, {8'h00, 3'b110}, 1'b0);
      run(5'h14, {8'h7f, 3'b100}, 1'b1);
      run(5'h18, {8'ha5, 3'b000}, 1'b0);
      final_report();
   end
endmodule // t1_transmit_formatter_tb
`default_nettype wire
